/* File: inc/cltl_pkg.sv */
// Constants shared by the CAN and LIN transceiver digital side.
// Assumes a 100 MHz system clock and a synchronous active-high reset.
package cltl_pkg;
  localparam int CLK_MHZ = 100;
  // LIN dominant timeout, in microseconds.
  localparam int LIN_DOM_TIMEOUT_US = 5000;
  localparam int LIN_DOM_TIMEOUT_CYC = LIN_DOM_TIMEOUT_US * CLK_MHZ;
  // CAN dominant timeout, in microseconds.
  localparam int CAN_DOM_TIMEOUT_US = 1000;
  localparam int CAN_DOM_TIMEOUT_CYC = CAN_DOM_TIMEOUT_US * CLK_MHZ;
  localparam int TMO_W = 32;
  localparam logic [TMO_W-1:0] TMO_ZERO = 32'h0000_0000;
  localparam logic [TMO_W-1:0] TMO_ONE = 32'h0000_0001;
  // Line levels.
  localparam logic LVL_DOM = 1'b0;
  localparam logic LVL_REC = 1'b1;
  localparam logic [2:0] SYNC_INIT = 3'h7;
  // LIN rate selection.
  typedef enum logic [1:0] {
    CLTL_RATE_NORMAL = 2'h0,
    CLTL_RATE_SLOW = 2'h1,
    CLTL_RATE_FAST = 2'h3
  } cltl_rate_t;
  localparam int RATE_NORMAL_KBPS = 20;
  localparam int RATE_SLOW_KBPS = 10;
  localparam int RATE_FAST_KBPS = 100;
  // Dominant guard states, Gray coded.
  typedef enum logic [1:0] {
    CLTL_G_IDLE = 2'h0,
    CLTL_G_DOM = 2'h1,
    CLTL_G_LOCK = 2'h3
  } cltl_guard_t;
endpackage : cltl_pkg

/* File: core/cltl_dom_guard.sv */
// Dominant-timeout guard for one transmit input.
// Assumes tx_dom comes already synchronised to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module cltl_dom_guard #(
  parameter int TIMEOUT_CYC = 500000
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tx_dom,
  output logic drive_en,
  output logic locked
);
  import cltl_pkg::*;
  localparam logic [TMO_W-1:0] LIMIT = TMO_W'(TIMEOUT_CYC);
  cltl_guard_t state_reg;
  logic [TMO_W-1:0] cnt_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= CLTL_G_IDLE;
      cnt_reg <= TMO_ZERO;
    end else begin
      case (state_reg)
        CLTL_G_IDLE: begin
          cnt_reg <= TMO_ZERO;
          if (tx_dom) begin
            state_reg <= CLTL_G_DOM;
            cnt_reg <= TMO_ONE;
          end
        end
        CLTL_G_DOM: begin
          if (!tx_dom) begin
            state_reg <= CLTL_G_IDLE;
          end else if (cnt_reg >= LIMIT) begin
            state_reg <= CLTL_G_LOCK;
          end else begin
            cnt_reg <= cnt_reg + TMO_ONE;
          end
        end
        CLTL_G_LOCK: begin
          if (!tx_dom) begin
            state_reg <= CLTL_G_IDLE;
          end
        end
        default: begin
          state_reg <= CLTL_G_IDLE;
        end
      endcase
    end
  end

  assign locked = (state_reg == CLTL_G_LOCK);
  assign drive_en = tx_dom && !locked;
endmodule : cltl_dom_guard
`default_nettype wire

/* File: core/cltl_core.sv */
// Digital side of the CAN FD and LIN transceivers.
// Assumes asynchronous pin inputs; bus drive outputs go to analog drivers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - CAN transmit high or floating keeps both CAN drivers off in normal mode.
// - CAN transmit low in normal mode switches both CAN drivers on.
// - CAN driving is disabled when transmit stays dominant past the CAN timeout.
// - CAN receive is push-pull bus level in normal mode and released in low-power-off.
// - In low-power-off the CAN drivers are off and transmit reads low.
// - LIN transistor is off for transmit high and on for transmit low in normal mode.
// - LIN driving is disabled when transmit stays dominant past the LIN timeout.
// - The LIN dominant timeout is nominally 5.0 ms.
// - LIN receive is push-pull bus level in normal mode and released in low-power-off.
// - LIN rate selects 20 kbit/s normal, 10 kbit/s slow or 100 kbit/s fast.
// - In low-power-off the LIN transistor is off and the line sits high.
module cltl_core #(
  parameter int CAN_TMO_CYC = cltl_pkg::CAN_DOM_TIMEOUT_CYC,
  parameter int LIN_TMO_CYC = cltl_pkg::LIN_DOM_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic low_power_off_mode,
  input wire logic can_tx_in,
  input wire logic can_bus_rx_level,
  output logic can_h_drive,
  output logic can_l_drive,
  output logic can_rx_out,
  output logic can_rx_oe_n,
  output logic can_timeout,
  input wire logic lin_tx_in,
  input wire logic lin_bus_rx_level,
  input wire cltl_pkg::cltl_rate_t lin_rate_sel,
  output logic lin_drive,
  output logic lin_rx_out,
  output logic lin_rx_oe_n,
  output logic lin_timeout,
  output logic [1:0] lin_slope_sel,
  output logic [6:0] lin_rate_kbps
);
  import cltl_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [2:0] can_tx_sync_reg;
  logic [2:0] lin_tx_sync_reg;
  logic [2:0] can_rx_sync_reg;
  logic [2:0] lin_rx_sync_reg;
  logic [2:0] lpo_sync_reg;
  logic can_tx_reg;
  logic lin_tx_reg;
  logic can_bus_reg;
  logic lin_bus_reg;
  logic lpo_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      can_tx_sync_reg <= SYNC_INIT;
      lin_tx_sync_reg <= SYNC_INIT;
      can_rx_sync_reg <= SYNC_INIT;
      lin_rx_sync_reg <= SYNC_INIT;
      lpo_sync_reg <= 3'h0;
    end else begin
      can_tx_sync_reg <= {can_tx_sync_reg[1:0], can_tx_in};
      lin_tx_sync_reg <= {lin_tx_sync_reg[1:0], lin_tx_in};
      can_rx_sync_reg <= {can_rx_sync_reg[1:0], can_bus_rx_level};
      lin_rx_sync_reg <= {lin_rx_sync_reg[1:0], lin_bus_rx_level};
      lpo_sync_reg <= {lpo_sync_reg[1:0], low_power_off_mode};
    end
  end

  // A change counts once stages two and three agree.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      can_tx_reg <= LVL_REC;
      lin_tx_reg <= LVL_REC;
      can_bus_reg <= LVL_REC;
      lin_bus_reg <= LVL_REC;
      lpo_reg <= 1'b0;
    end else begin
      if (can_tx_sync_reg[1] == can_tx_sync_reg[2]) begin
        can_tx_reg <= can_tx_sync_reg[2];
      end
      if (lin_tx_sync_reg[1] == lin_tx_sync_reg[2]) begin
        lin_tx_reg <= lin_tx_sync_reg[2];
      end
      if (can_rx_sync_reg[1] == can_rx_sync_reg[2]) begin
        can_bus_reg <= can_rx_sync_reg[2];
      end
      if (lin_rx_sync_reg[1] == lin_rx_sync_reg[2]) begin
        lin_bus_reg <= lin_rx_sync_reg[2];
      end
      if (lpo_sync_reg[1] == lpo_sync_reg[2]) begin
        lpo_reg <= lpo_sync_reg[2];
      end
    end
  end

  // ==========================================================
  // Dominant guards
  logic can_dom;
  logic lin_dom;
  logic can_en;
  logic lin_en;
  logic can_lock;
  logic lin_lock;

  assign can_dom = (can_tx_reg == LVL_DOM) && !lpo_reg;
  assign lin_dom = (lin_tx_reg == LVL_DOM) && !lpo_reg;

  cltl_dom_guard #(
    .TIMEOUT_CYC(CAN_TMO_CYC)
  ) u_can_guard (
    .clk_sys(clk_sys),
    .reset(reset),
    .tx_dom(can_dom),
    .drive_en(can_en),
    .locked(can_lock)
  );

  cltl_dom_guard #(
    .TIMEOUT_CYC(LIN_TMO_CYC)
  ) u_lin_guard (
    .clk_sys(clk_sys),
    .reset(reset),
    .tx_dom(lin_dom),
    .drive_en(lin_en),
    .locked(lin_lock)
  );

  // ==========================================================
  // Bus drive and receive outputs
  // CAN driver control.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      can_h_drive <= 1'b0;
      can_l_drive <= 1'b0;
      can_timeout <= 1'b0;
    end else begin
      can_h_drive <= can_en;
      can_l_drive <= can_en;
      can_timeout <= can_lock;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lin_drive <= 1'b0;
      lin_timeout <= 1'b0;
    end else begin
      lin_drive <= lin_en;
      lin_timeout <= lin_lock;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      can_rx_out <= LVL_REC;
      lin_rx_out <= LVL_REC;
      can_rx_oe_n <= 1'b1;
      lin_rx_oe_n <= 1'b1;
    end else begin
      can_rx_out <= can_bus_reg;
      lin_rx_out <= lin_bus_reg;
      can_rx_oe_n <= lpo_reg;
      lin_rx_oe_n <= lpo_reg;
    end
  end

  // ==========================================================
  // LIN rate selection
  // Rate decode.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lin_slope_sel <= CLTL_RATE_NORMAL;
      lin_rate_kbps <= 7'(RATE_NORMAL_KBPS);
    end else begin
      case (lin_rate_sel)
        CLTL_RATE_SLOW: begin
          lin_slope_sel <= CLTL_RATE_SLOW;
          lin_rate_kbps <= 7'(RATE_SLOW_KBPS);
        end
        CLTL_RATE_FAST: begin
          lin_slope_sel <= CLTL_RATE_FAST;
          lin_rate_kbps <= 7'(RATE_FAST_KBPS);
        end
        default: begin
          lin_slope_sel <= CLTL_RATE_NORMAL;
          lin_rate_kbps <= 7'(RATE_NORMAL_KBPS);
        end
      endcase
    end
  end

  // ==========================================================
  // Assertions
  sequence s_can_dom_in;
    can_dom && !can_lock;
  endsequence

  property p_can_drive;
    @(posedge clk_sys) disable iff (reset)
      s_can_dom_in |=> can_h_drive && can_l_drive;
  endproperty
  a_can_drive: assert property (p_can_drive) else $error("CAN not driven dominant");

  property p_can_rec;
    @(posedge clk_sys) disable iff (reset)
      !can_dom |=> !can_h_drive && !can_l_drive;
  endproperty
  a_can_rec: assert property (p_can_rec) else $error("CAN driven while recessive");

  property p_can_lock;
    @(posedge clk_sys) disable iff (reset)
      can_lock |=> !can_h_drive && can_timeout;
  endproperty
  a_can_lock: assert property (p_can_lock) else $error("CAN driven after timeout");

  property p_lock_hold;
    @(posedge clk_sys) disable iff (reset)
      can_lock && can_dom |=> can_lock;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("CAN lock released early");

  property p_lpo;
    @(posedge clk_sys) disable iff (reset)
      lpo_reg [*2] |-> !can_h_drive && !lin_drive && can_rx_oe_n && lin_rx_oe_n;
  endproperty
  a_lpo: assert property (p_lpo) else $error("Driving in low-power-off");

  property p_lin_drive;
    @(posedge clk_sys) disable iff (reset)
      lin_dom && !lin_lock |=> lin_drive;
  endproperty
  a_lin_drive: assert property (p_lin_drive) else $error("LIN not driven");

  property p_lin_lock;
    @(posedge clk_sys) disable iff (reset)
      lin_lock |=> !lin_drive && lin_timeout;
  endproperty
  a_lin_lock: assert property (p_lin_lock) else $error("LIN driven after timeout");

  property p_lpo_lin;
    @(posedge clk_sys) disable iff (reset)
      lpo_reg |=> !lin_drive;
  endproperty
  a_lpo_lin: assert property (p_lpo_lin) else $error("LIN on in low-power-off");

  property p_rx;
    @(posedge clk_sys) disable iff (reset)
      !lpo_reg |=> !can_rx_oe_n && (can_rx_out == $past(can_bus_reg));
  endproperty
  a_rx: assert property (p_rx) else $error("CAN receive wrong");

  property p_lin_rx;
    @(posedge clk_sys) disable iff (reset)
      !lpo_reg |=> !lin_rx_oe_n && (lin_rx_out == $past(lin_bus_reg));
  endproperty
  a_lin_rx: assert property (p_lin_rx) else $error("LIN receive wrong");

  property p_rate;
    @(posedge clk_sys) disable iff (reset)
      lin_rate_sel == CLTL_RATE_FAST |=> lin_rate_kbps == 7'(RATE_FAST_KBPS);
  endproperty
  a_rate: assert property (p_rate) else $error("LIN fast rate wrong");

  property p_rate_slow;
    @(posedge clk_sys) disable iff (reset)
      lin_rate_sel == CLTL_RATE_SLOW |=> lin_rate_kbps == 7'(RATE_SLOW_KBPS);
  endproperty
  a_rate_slow: assert property (p_rate_slow) else $error("LIN slow rate wrong");

  property p_rate_norm;
    @(posedge clk_sys) disable iff (reset)
      lin_rate_sel == CLTL_RATE_NORMAL |=> lin_rate_kbps == 7'(RATE_NORMAL_KBPS);
  endproperty
  a_rate_norm: assert property (p_rate_norm) else $error("LIN normal rate wrong");

  property p_can_pair;
    @(posedge clk_sys) disable iff (reset)
      can_h_drive == can_l_drive;
  endproperty
  a_can_pair: assert property (p_can_pair) else $error("CAN drivers split");

  property p_lin_rec;
    @(posedge clk_sys) disable iff (reset)
      !lin_dom |=> !lin_drive;
  endproperty
  a_lin_rec: assert property (p_lin_rec) else $error("LIN driven while recessive");

  property p_lin_hold;
    @(posedge clk_sys) disable iff (reset)
      lin_lock && lin_dom |=> lin_lock;
  endproperty
  a_lin_hold: assert property (p_lin_hold) else $error("LIN lock released early");

  // The lock drops first and the timeout flag follows one edge later.
  sequence s_can_release;
    !can_lock ##1 !can_timeout;
  endsequence

  property p_lock_clear;
    @(posedge clk_sys) disable iff (reset)
      can_lock && !can_dom |=> s_can_release;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("CAN lock not cleared");
endmodule : cltl_core
`default_nettype wire

/* File: tb/cltl_mcu_model.sv */
// Behavioural model of the controller pins that drive both transmit inputs.
// Assumes the bench asks for bus levels on can_bit and lin_bit at clk_sys edges.
`timescale 1ns/1ps
`default_nettype none
module cltl_mcu_model #(
  parameter int READY_CYC = 8
) (
  input wire logic clk_sys,
  input wire logic io_supply_on,
  input wire logic can_bit,
  input wire logic lin_bit,
  output logic can_tx_in,
  output logic lin_tx_in
);
  int ready_cnt_reg = 0;
  always_ff @(posedge clk_sys) begin
    if (!io_supply_on) begin
      ready_cnt_reg <= 0;
    end else if (ready_cnt_reg < READY_CYC) begin
      ready_cnt_reg <= ready_cnt_reg + 1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!io_supply_on) begin
      can_tx_in <= 1'b0;
      lin_tx_in <= 1'b0;
    end else if (ready_cnt_reg < READY_CYC) begin
      can_tx_in <= 1'b1;
      lin_tx_in <= 1'b1;
    end else begin
      can_tx_in <= can_bit;
      lin_tx_in <= lin_bit;
    end
  end
endmodule : cltl_mcu_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the transceiver digital side.
// Assumes short timeout parameters and a bus that echoes the drivers.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cltl_pkg::*;
  localparam int CAN_T = 20;
  localparam int LIN_T = 30;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic lpo = 1'b0;
  logic io_on = 1'b1;
  logic can_req = 1'b1;
  logic lin_req = 1'b1;
  cltl_rate_t rate = CLTL_RATE_NORMAL;
  logic can_tx, lin_tx, can_h, can_l, can_rx, can_oe_n, can_to;
  logic lin_drv, lin_rx, lin_oe_n, lin_to;
  logic [1:0] slope;
  logic [6:0] kbps;
  int n_fail = 0;
  int n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  cltl_mcu_model i_cltl_mcu_model (.clk_sys(clk_sys), .io_supply_on(io_on),
    .can_bit(can_req), .lin_bit(lin_req), .can_tx_in(can_tx), .lin_tx_in(lin_tx));
  cltl_core #(.CAN_TMO_CYC(CAN_T), .LIN_TMO_CYC(LIN_T)) i_cltl_core (
    .clk_sys(clk_sys), .reset(reset), .low_power_off_mode(lpo),
    .can_tx_in(can_tx), .can_bus_rx_level(~(can_h & can_l)),
    .can_h_drive(can_h), .can_l_drive(can_l), .can_rx_out(can_rx),
    .can_rx_oe_n(can_oe_n), .can_timeout(can_to), .lin_tx_in(lin_tx),
    .lin_bus_rx_level(~lin_drv), .lin_rate_sel(rate), .lin_drive(lin_drv),
    .lin_rx_out(lin_rx), .lin_rx_oe_n(lin_oe_n), .lin_timeout(lin_to),
    .lin_slope_sel(slope), .lin_rate_kbps(kbps));
  // ==========================================================
  // Helpers
  task automatic wrap_up();
    $display("compared %0d, wrong %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [6:0] got, input logic [6:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : settle
  function automatic logic drv(input bit is_lin);
    return is_lin ? lin_drv : (can_h & can_l);
  endfunction : drv
  // ==========================================================
  // Scenarios
  task automatic t_levels();
    @(posedge clk_sys);
    can_req <= 1'b0;
    lin_req <= 1'b0;
    settle();
    chk(7'({can_h, can_l}), 7'h03, "can drivers on");
    settle();
    chk(7'(can_rx), 7'h00, "can rx dominant");
    chk(7'(lin_drv), 7'h01, "lin driver on");
    chk(7'(lin_rx), 7'h00, "lin rx dominant");
    @(posedge clk_sys);
    can_req <= 1'b1;
    lin_req <= 1'b1;
    settle();
    chk(7'({can_h, can_l}), 7'h00, "can drivers off");
    settle();
    chk(7'({can_rx, lin_rx, lin_drv}), 7'h06, "recessive levels");
  endtask : t_levels
  task automatic t_tmo(input bit is_lin);
    int n;
    int lim;
    lim = is_lin ? LIN_T : CAN_T;
    n = 0;
    @(posedge clk_sys);
    if (is_lin) lin_req <= 1'b0;
    else can_req <= 1'b0;
    settle();
    chk(7'(drv(is_lin)), 7'h01, "dominant drive");
    while (drv(is_lin) === 1'b1 && n < lim + 10) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= lim + 10) begin
      n_fail++;
      $display("wrong value at %0t: timeout never came", $time);
      wrap_up();
    end
    chk(7'(n >= lim - 4 && n <= lim + 2), 7'h01, "timeout length");
    chk(7'(is_lin ? lin_to : can_to), 7'h01, "lock flag");
    repeat (20) @(posedge clk_sys);
    #1;
    chk(7'(drv(is_lin)), 7'h00, "lock held");
    @(posedge clk_sys);
    if (is_lin) lin_req <= 1'b1;
    else can_req <= 1'b1;
    settle();
    settle();
    chk(7'(is_lin ? lin_to : can_to), 7'h00, "lock cleared");
    @(posedge clk_sys);
    if (is_lin) lin_req <= 1'b0;
    else can_req <= 1'b0;
    settle();
    chk(7'(drv(is_lin)), 7'h01, "drive after unlock");
    @(posedge clk_sys);
    can_req <= 1'b1;
    lin_req <= 1'b1;
    settle();
  endtask : t_tmo
  task automatic t_rate();
    cltl_rate_t codes [4];
    int exp_k [4];
    logic [1:0] exp_s [4];
    codes = '{CLTL_RATE_SLOW, CLTL_RATE_FAST, cltl_rate_t'(2'h2), CLTL_RATE_NORMAL};
    exp_k = '{RATE_SLOW_KBPS, RATE_FAST_KBPS, RATE_NORMAL_KBPS, RATE_NORMAL_KBPS};
    exp_s = '{2'h1, 2'h3, 2'h0, 2'h0};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      rate <= codes[i];
      settle();
      chk(kbps, 7'(exp_k[i]), "rate kbps");
      chk(7'(slope), 7'(exp_s[i]), "slope select");
    end
  endtask : t_rate
  task automatic t_lpo();
    @(posedge clk_sys);
    lpo <= 1'b1;
    io_on <= 1'b0;
    settle();
    chk(7'({can_h, can_l, lin_drv}), 7'h00, "drivers off");
    chk(7'({can_oe_n, lin_oe_n}), 7'h03, "rx released");
    // The supply returns first so transmit is already recessive on wake.
    @(posedge clk_sys);
    io_on <= 1'b1;
    repeat (2) @(posedge clk_sys);
    lpo <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      #1;
      chk(7'({can_h, can_l, lin_drv}), 7'h00, "no drive on wake");
    end
    settle();
    chk(7'({can_oe_n, lin_oe_n, can_h, lin_drv}), 7'h00, "back to normal");
  endtask : t_lpo
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    chk(7'({can_h, lin_drv, can_oe_n, lin_oe_n}), 7'h03, "reset outputs");
    chk(kbps, 7'(RATE_NORMAL_KBPS), "reset rate");
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (12) @(posedge clk_sys);
    settle();
    chk(7'({can_oe_n, lin_oe_n, can_rx, lin_rx}), 7'h03, "idle levels");
    t_levels();
    t_tmo(1'b0);
    t_tmo(1'b1);
    t_rate();
    t_lpo();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
